// >>> pkg/gpr_pkg.sv
package gpr_pkg;
  localparam int GPR_PINS = 16;
  localparam logic [7:0] GPR_PULL_OFS = 8'h0C;
  localparam logic [7:0] GPR_ISTAT_OFS = 8'h10;
  localparam logic [7:0] GPR_OCTL_OFS = 8'h14;
  localparam logic [7:0] GPR_BSC_OFS = 8'h18;
  localparam logic [31:0] GPR_PULL_RST_FIRST = 32'h2400_0000;
  localparam logic [31:0] GPR_PULL_RST_OTHER = 32'h0000_0000;
  localparam logic [15:0] GPR_OCTL_RST = 16'h0000;
  localparam logic [15:0] GPR_ISTAT_RST = 16'h0000;
  localparam logic [1:0] GPR_PULL_FLOAT = 2'h0;
  localparam logic [1:0] GPR_PULL_UP = 2'h1;
  localparam logic [1:0] GPR_PULL_DOWN = 2'h2;
  localparam int GPR_SET_LSB = 0;
  localparam int GPR_CLR_LSB = 16;
endpackage

// >>> logic/gpr_port.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - two-bit pull code per pin: 00 float, 01 pull-up, 10 pull-down, 11 reserved
// R2 - pull register resets to 0x24000000 on first port, zero elsewhere
// R3 - pin y pull field sits at bits 2y+1:2y, all read-write
// R4 - pull and output registers take byte, half-word or word writes per lane
// R5 - input status low half follows sampled pins; writes ignored
// R6 - software reads input status only as full words
// R7 - input status upper half reads zero; lower half tracks pins
// R8 - output bit y drives pin y level; resets zero, software writes
// R9 - output register read only as full words by software
// R10 - set/clear low half bit y written 1 sets output bit y
// R11 - set/clear bit 16+y written 1 clears output bit y
// R12 - set/clear register is write-only, reads zero, any width, stores nothing
// R13 - software keeps upper reserved halves at reset value when writing
// R14 - set and clear together for one pin: set wins
module gpr_port
  import gpr_pkg::*;
#(
  parameter bit FIRST_PORT = 1'b1
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_pull_up,
  output logic [15:0] pad_pull_down
);

  localparam logic [31:0] PULL_RST =
    FIRST_PORT ? GPR_PULL_RST_FIRST : GPR_PULL_RST_OTHER;

  function automatic logic [31:0] gpr_lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // reserved code 11 matches neither code, so it drives neither resistor
  function automatic logic [15:0] gpr_pull_decode(
    input logic [31:0] v,
    input logic [1:0] code
  );
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < GPR_PINS; i++)
    begin
      r[i] = v[2*i +: 2] == code;
    end
    return r;
  endfunction

  localparam logic [15:0] UP_RST =
    gpr_pull_decode(PULL_RST, GPR_PULL_UP);
  localparam logic [15:0] DOWN_RST =
    gpr_pull_decode(PULL_RST, GPR_PULL_DOWN);

  logic [31:0] pull_ff;
  logic [15:0] in_ff;
  logic [15:0] octl_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic err_ff;
  logic [15:0] up_ff;
  logic [15:0] down_ff;

  // access phase: answer takes one wait cycle then completes
  wire setup_ok = psel && penable && !ready_ff;
  wire wr_en = setup_ok && pwrite;
  wire rd_en = setup_ok && !pwrite;
  wire hit_pull = paddr == GPR_PULL_OFS;
  wire hit_istat = paddr == GPR_ISTAT_OFS;
  wire hit_octl = paddr == GPR_OCTL_OFS;
  wire hit_bsc = paddr == GPR_BSC_OFS;
  wire mapped = hit_pull || hit_istat || hit_octl || hit_bsc;
  wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                           {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] bsc_eff = pwdata & strb_mask; // R12
  wire [15:0] set_req = bsc_eff[GPR_SET_LSB +: 16]; // R10
  wire [15:0] clr_req = bsc_eff[GPR_CLR_LSB +: 16]; // R11
  wire [31:0] nxt_pull = (wr_en && hit_pull) ?
    gpr_lane_merge(pull_ff, pwdata, pstrb) : pull_ff; // R3 R4
  wire [31:0] octl_merge = gpr_lane_merge({16'h0000, octl_ff}, pwdata, pstrb);
  // set applied last so it wins a same-pin collision
  wire [15:0] octl_bsc = (octl_ff & ~clr_req) | set_req; // R10 R11 R14
  wire [15:0] nxt_octl = (wr_en && hit_octl) ? octl_merge[15:0] : // R4 R8
    (wr_en && hit_bsc) ? octl_bsc : octl_ff;
  // reserved upper halves and the write-only register read zero
  wire [31:0] rd_mux = hit_pull ? pull_ff :
    hit_istat ? {16'h0000, in_ff} : // R7
    hit_octl ? {16'h0000, octl_ff} : 32'h0000_0000; // R12

  wire [15:0] nxt_up = gpr_pull_decode(nxt_pull, GPR_PULL_UP); // R1 R3
  wire [15:0] nxt_down = gpr_pull_decode(nxt_pull, GPR_PULL_DOWN); // R1 R3

  // decode the next value so the pad controls change with the register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_ff <= UP_RST; // R2
      down_ff <= DOWN_RST; // R2
    end
    else
    begin
      up_ff <= nxt_up;
      down_ff <= nxt_down;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pull_ff <= PULL_RST; // R2
    end
    else
    begin
      pull_ff <= nxt_pull;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      octl_ff <= GPR_OCTL_RST; // R8
    end
    else
    begin
      octl_ff <= nxt_octl;
    end
  end

  // writes never reach the input snapshot
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_ff <= GPR_ISTAT_RST;
    end
    else
    begin
      in_ff <= pad_in; // R5
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_ff <= 1'b0;
    end
    else
    begin
      ready_ff <= setup_ok;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_ff <= 1'b0;
    end
    else
    begin
      err_ff <= setup_ok && !mapped;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign pad_out = octl_ff; // R8
  assign pad_pull_up = up_ff;
  assign pad_pull_down = down_ff;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_SET_WINS: assert property ( // R14
    wr_en && hit_bsc && pstrb == 4'hF && pwdata[0] && pwdata[16]
    |=> octl_ff[0])
    else $error("set and clear together did not set");
  AST_SET: assert property ( // R10
    wr_en && hit_bsc && pstrb[0] && pwdata[3] |=> octl_ff[3])
    else $error("set request missed");
  AST_CLR: assert property ( // R11
    wr_en && hit_bsc && pstrb[2] && pwdata[18] && !(pstrb[0] && pwdata[2])
    |=> !octl_ff[2])
    else $error("clear request missed");
  AST_BSC_NOOP: assert property ( // R12
    wr_en && hit_bsc && bsc_eff == 32'h0000_0000 |=> $stable(octl_ff))
    else $error("empty set/clear write changed output");
  AST_IN_TRACK: assert property ( // R5
    ##1 in_ff == $past(pad_in))
    else $error("input snapshot not tracking pins");
  AST_IN_READ: assert property ( // R7
    rd_en && hit_istat |=> prdata[31:16] == 16'h0000 && pready)
    else $error("input status upper half not zero");
  AST_LANE: assert property ( // R4
    wr_en && hit_pull && pstrb == 4'h1
    |=> pull_ff[31:8] == $past(pull_ff[31:8]))
    else $error("byte write touched other lanes");
  AST_PULL_DEC: assert property ( // R1
    pull_ff[1:0] == GPR_PULL_UP |-> up_ff[0] && !down_ff[0])
    else $error("pull-up code not decoded");
  AST_PAD_OUT: assert property ( // R8
    wr_en && hit_octl && pstrb[0] |=> pad_out[7:0] == $past(pwdata[7:0]))
    else $error("output write not on pads");
  AST_ANSWER: assert property ( // APB answer timing
    setup_ok |=> pready ##1 !pready)
    else $error("bus answer not one cycle");


  // pull decode checked against the register on pins 0 and 15
  AST_PULL_DOWN_DEC: assert property ( // R1
    pull_ff[1:0] == GPR_PULL_DOWN |-> down_ff[0] && !up_ff[0])
    else $error("pull-down code not decoded");

  AST_PULL_FLOAT: assert property ( // R1
    pull_ff[1:0] == GPR_PULL_FLOAT |-> !up_ff[0] && !down_ff[0])
    else $error("floating code enabled a resistor");

  AST_PULL_RSVD: assert property ( // R1
    pull_ff[1:0] == ~GPR_PULL_FLOAT |-> !up_ff[0] && !down_ff[0])
    else $error("reserved code enabled a resistor");

  AST_PULL_TOP: assert property ( // R3
    pull_ff[31:30] == GPR_PULL_DOWN |-> down_ff[15] && !up_ff[15])
    else $error("top pin field not decoded");

  AST_NO_BOTH: assert property ( // R1
    (up_ff & down_ff) == 16'h0000)
    else $error("pull-up and pull-down both enabled");

  AST_PULL_READ: assert property ( // R3
    rd_en && hit_pull |=> prdata == $past(pull_ff))
    else $error("pull register read back wrong");

  AST_PULL_WORD: assert property ( // R4
    wr_en && hit_pull && pstrb == 4'hF |=> pull_ff == $past(pwdata))
    else $error("word write to pull register lost");

  AST_PULL_HOLD: assert property ( // R3
    !(wr_en && hit_pull) |=> $stable(pull_ff))
    else $error("pull register changed without a write");

  // output register only moves on its own write or a set/clear
  AST_OCTL_READ: assert property ( // R8
    rd_en && hit_octl |=> prdata == {16'h0000, $past(octl_ff)})
    else $error("output register read back wrong");

  AST_OCTL_LANE: assert property ( // R4
    wr_en && hit_octl && pstrb == 4'h2
    |=> octl_ff[7:0] == $past(octl_ff[7:0]))
    else $error("output byte write touched other lane");

  AST_OCTL_HOLD: assert property ( // R8
    !(wr_en && (hit_octl || hit_bsc)) |=> $stable(octl_ff))
    else $error("output register changed without a write");

  AST_BSC_READ: assert property ( // R12
    rd_en && hit_bsc |=> prdata == 32'h0000_0000)
    else $error("set/clear register read not zero");

  AST_SET_LANE: assert property ( // R10
    wr_en && hit_bsc && pstrb == 4'h3
    |=> (octl_ff & $past(octl_ff)) == $past(octl_ff))
    else $error("set-only write cleared an output");

  AST_CLR_LANE: assert property ( // R11
    wr_en && hit_bsc && pstrb == 4'hC
    |=> (octl_ff | $past(octl_ff)) == $past(octl_ff))
    else $error("clear-only write set an output");

  COV_COLLIDE: cover property (wr_en && hit_bsc && |(set_req & clr_req));
  COV_BSC: cover property (wr_en && hit_bsc);
  COV_OCTL: cover property (wr_en && hit_octl);
  COV_PULL_RD: cover property (rd_en && hit_pull);
  COV_ERR: cover property (pslverr);
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import gpr_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] pad_in, pad_out, pad_pull_up, pad_pull_down;
  int mismatches, n_compared, cycles;
  gpr_port #(.FIRST_PORT(1'b1)) DUT (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down));
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; the request holds until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_reset();
    logic e;
    chk({pad_pull_down, pad_pull_up}, 32'h4000_2000);
    apb(1'b0, GPR_PULL_OFS, 32'h0, 4'hF, e);
    chk(rd, 32'h2400_0000);
    apb(1'b0, GPR_OCTL_OFS, 32'h0, 4'hF, e);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_pull();
    logic e;
    apb(1'b1, GPR_PULL_OFS, 32'hFFE4_0001, 4'h1, e);
    apb(1'b1, GPR_PULL_OFS, 32'h9055_5555, 4'h8, e);
    apb(1'b0, GPR_PULL_OFS, 32'h0, 4'hF, e);
    chk(rd, 32'h9000_0001);
    chk({pad_pull_down, pad_pull_up}, 32'h8000_4001);
  endtask
  task automatic t_istat();
    logic e;
    pad_in <= 16'hA5C3;
    apb(1'b1, GPR_ISTAT_OFS, 32'h0000_FFFF, 4'hF, e);
    apb(1'b0, GPR_ISTAT_OFS, 32'h0, 4'hF, e);
    chk(rd, 32'h0000_A5C3);
  endtask
  task automatic t_octl();
    logic e;
    apb(1'b1, GPR_OCTL_OFS, 32'h0000_1234, 4'h2, e);
    chk({16'h0, pad_out}, 32'h0000_1200);
    // bit 0 asks set and clear at once; bit 9 only clear
    apb(1'b1, GPR_BSC_OFS, 32'h0201_0005, 4'hF, e);
    chk({16'h0, pad_out}, 32'h0000_1005);
    apb(1'b1, GPR_BSC_OFS, 32'h1000_0100, 4'h4, e);
    chk({16'h0, pad_out}, 32'h0000_1005);
    apb(1'b1, GPR_BSC_OFS, 32'h1000_0000, 4'h8, e);
    chk({16'h0, pad_out}, 32'h0000_0005);
    apb(1'b0, GPR_BSC_OFS, 32'h0, 4'hF, e);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0, 4'hF, e);
    chk({e, rd[30:0]}, 32'h8000_0000);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    pad_in = 16'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_pull();
    t_istat();
    t_octl();
    give_verdict();
  end
endmodule
